/* icrm_fetch_model.sv */
// Processor fetch port model: one request, then its single answer.
// Assumes the cache answers on the cycle after the request edge.
`timescale 1ns/1ns
module icrm_fetch_model (
   input  wire logic        sys_clk,
   output logic             fetch_req,
   output logic [31:0]      fetch_addr,
   input  wire logic        fetch_hit,
   input  wire logic        fetch_fill
);
   initial begin
      fetch_req  = 1'h0;
      fetch_addr = 32'h0;
   end
   task automatic fetch(input logic [31:0] a, output logic [31:0] r);
      @(posedge sys_clk);
      fetch_req  <= 1'h1;
      fetch_addr <= a;
      @(posedge sys_clk);
      fetch_req  <= 1'h0;
      // Address not held past the request, so scramble it
      fetch_addr <= ~a;
      @(posedge sys_clk);
      r = {30'h0, fetch_hit, fetch_fill};
   endtask
endmodule

/* icrm_instr_cache_ram_mgmt.sv */
// Instruction cache control registers, tag store and on-chip RAM zeroize/sleep/shutdown control.
// Assumes an APB-style register port on sys_clk and RAM control inputs synchronous to sys_clk.
// Behaviour
// - ID register returns instance id 15:10, part number 9:6, release 5:0.
// - Size register bits 31:16 give addressable memory in 128KB units.
// - Size register bits 15:0 give cache RAM in 1KB units, here 16.
// - Ready flag clears whenever whole cache is invalidated, including after reset.
// - Ready sets by itself once invalidation completes.
// - While ready is 0, fetches bypass cache through line fill buffer.
// - Enable resets to 0; writing it 0 while it is 1 invalidates the whole cache.
// - While disabled, fetches are served by the line fill buffer.
// - Any write to invalidate register invalidates whole cache.
// - Zeroization writes all-zero data to every location.
// - Data RAM clear request zeroizes the entire data RAM.
// - Cache RAM clear request zeroizes cache data RAM and tag RAM.
// - Light Sleep gates the RAM clock and blocks access.
// - RAM contents are kept during Light Sleep.
// - Light Sleep controlled separately for data RAM and cache RAM.
// - Leaving Light Sleep restores access to that RAM.
// - Shutdown gates power and clock, loses contents, blocks access.
// - RAM leaving shutdown is cleared.
// - Firmware enables then polls ready; ready rises only after invalidation.
// - Cache has line buffer, tag RAM and 16KB two-way data RAM.
`timescale 1ns/1ns
`include "icrm_regs.svh"
module icrm_instr_cache_ram_mgmt
   import icrm_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fetch_req,
   input  wire logic [31:0] fetch_addr,
   output logic             fetch_hit,
   output logic             fetch_fill,
   input  wire logic        dram_zero_req,
   input  wire logic        cram_zero_req,
   input  wire logic        dram_light_sleep,
   input  wire logic        cram_light_sleep,
   input  wire logic        dram_shutdown,
   input  wire logic        cram_shutdown,
   output logic             dram_zero_we,
   output logic [11:0]      dram_addr,
   output logic             dram_busy,
   output logic             cram_zero_we,
   output logic [8:0]       cram_addr,
   output logic             dram_clk_en,
   output logic             dram_pwr_en,
   output logic             cram_clk_en,
   output logic             cram_pwr_en
);
   localparam logic [`ICRM_IDX_W-1:0] IDX0 = '0;

   icrm_state_t st;
   icrm_state_t next_st;

   // Two-way tag store with one LRU bit per set; data lines live in the cache RAM outside
   logic [`ICRM_TAG_W-1:0] tag_mem   [2][`ICRM_SETS];
   logic                   valid_mem [2][`ICRM_SETS];
   logic                   lru_mem   [`ICRM_SETS];

   logic                   sweep_we;
   logic                   fill_we;
   logic                   fill_way;
   logic [`ICRM_IDX_W-1:0] wr_idx;
   logic [`ICRM_TAG_W-1:0] fill_tag;

   function automatic logic [`ICRM_IDX_W-1:0] set_of(input logic [31:0] a);
      set_of = a[`ICRM_OFS_W +: `ICRM_IDX_W];
   endfunction
   function automatic logic [`ICRM_TAG_W-1:0] tag_of(input logic [31:0] a);
      tag_of = a[31 -: `ICRM_TAG_W];
   endfunction

   logic cram_ok;
   logic dram_ok;
   logic setup;
   logic start_inv;
   logic start_cz;
   logic hit0;
   logic hit1;

   always_comb begin
      next_st = st;
      sweep_we = 1'b0;
      fill_we = 1'b0;
      fill_way = 1'b0;
      wr_idx = IDX0;
      fill_tag = '0;
      start_inv = 1'b0;
      start_cz = 1'b0;
      hit0 = 1'b0;
      hit1 = 1'b0;
      // Sleep and shutdown are separate per RAM
      cram_ok = !cram_light_sleep && !cram_shutdown;
      dram_ok = !dram_light_sleep && !dram_shutdown;
      setup = psel && !penable;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.fetch_hit = 1'b0;
      next_st.fetch_fill = 1'b0;
      next_st.dram_zero_we = 1'b0;
      next_st.cram_zero_we = 1'b0;
      next_st.dram_clk_en = dram_ok;
      next_st.cram_clk_en = cram_ok;
      next_st.dram_pwr_en = !dram_shutdown;
      next_st.cram_pwr_en = !cram_shutdown;
      next_st.dsd_q = dram_shutdown;
      next_st.csd_q = cram_shutdown;

      // Answer in the access phase, so every read word is a flop
      if (setup) begin
         next_st.pready = 1'b1;
         next_st.prdata = '0;
         case (paddr)
            `ICRM_OFF_ID: begin
               if (!pwrite)
                  next_st.prdata = {16'h0000, `ICRM_CCHID, `ICRM_PARTNUM, `ICRM_RELNUM};
            end
            `ICRM_OFF_SIZE: begin
               if (!pwrite)
                  next_st.prdata = {`ICRM_MEMSZ_128K, `ICRM_CACHE_KB};
            end
            `ICRM_OFF_CTRL: begin
               if (pwrite) begin
                  next_st.enable = pwdata[`ICRM_CTRL_EN];
                  if (st.enable && !pwdata[`ICRM_CTRL_EN])
                     start_inv = 1'b1;
               end else begin
                  next_st.prdata[`ICRM_CTRL_READY] = st.ready;
                  next_st.prdata[`ICRM_CTRL_EN] = st.enable;
               end
            end
            `ICRM_OFF_INVAL: begin
               if (pwrite)
                  start_inv = 1'b1;
            end
            default: next_st.pslverr = 1'b1;
         endcase
      end

      if (cram_zero_req || (st.csd_q && !cram_shutdown))
         start_cz = 1'b1;

      // Cache sweep: clears valid bits, or tags too when zeroizing
      if (start_cz) begin
         next_st.sweep = ICRM_SW_CZERO;
         next_st.set_idx = IDX0;
         next_st.ready = 1'b0;
      end else if (start_inv && st.sweep != ICRM_SW_CZERO) begin
         next_st.sweep = ICRM_SW_INVAL;
         next_st.set_idx = IDX0;
         next_st.ready = 1'b0;
      end else begin
         case (st.sweep)
            ICRM_SW_IDLE: ;
            ICRM_SW_INVAL,
            ICRM_SW_CZERO: begin
               // Stalls while the cache RAM is asleep or off, so no set is skipped
               if (cram_ok) begin
                  sweep_we = 1'b1;
                  wr_idx = st.set_idx;
                  next_st.cram_zero_we = (st.sweep == ICRM_SW_CZERO);
                  next_st.cram_addr = st.set_idx;
                  if (st.set_idx == `ICRM_LAST_SET) begin
                     next_st.sweep = ICRM_SW_IDLE;
                     next_st.ready = 1'b1;
                  end else begin
                     next_st.set_idx = st.set_idx + 9'h001;
                  end
               end
            end
            default: next_st.sweep = ICRM_SW_IDLE;
         endcase
      end
      // Contents are lost while off; light sleep alone keeps them
      if (cram_shutdown)
         next_st.ready = 1'b0;

      // Data RAM zeroize walk
      if (dram_zero_req || (st.dsd_q && !dram_shutdown)) begin
         next_st.dz_busy = 1'b1;
         next_st.dz_addr = '0;
      end else if (st.dz_busy && dram_ok) begin
         next_st.dram_zero_we = 1'b1;
         next_st.dram_addr = st.dz_addr;
         if (st.dz_addr == `ICRM_DRAM_LAST)
            next_st.dz_busy = 1'b0;
         else
            next_st.dz_addr = st.dz_addr + 12'h001;
      end

      // Fetch path
      if (fetch_req) begin
         if (st.enable && st.ready && cram_ok) begin
            hit0 = valid_mem[0][set_of(fetch_addr)]
                   && tag_mem[0][set_of(fetch_addr)] == tag_of(fetch_addr);
            hit1 = valid_mem[1][set_of(fetch_addr)]
                   && tag_mem[1][set_of(fetch_addr)] == tag_of(fetch_addr);
            if (hit0 || hit1) begin
               next_st.fetch_hit = 1'b1;
            end else begin
               // Miss goes through the line fill buffer and is allocated to the LRU way
               next_st.fetch_fill = 1'b1;
               fill_we = 1'b1;
               fill_way = lru_mem[set_of(fetch_addr)];
               wr_idx = set_of(fetch_addr);
               fill_tag = tag_of(fetch_addr);
            end
         end else begin
            next_st.fetch_fill = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
         st.enable <= `ICRM_EN_RST;
         st.sweep <= ICRM_SW_INVAL;
         st.dram_clk_en <= 1'b1;
         st.dram_pwr_en <= 1'b1;
         st.cram_clk_en <= 1'b1;
         st.cram_pwr_en <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Tag store has no reset; the reset sweep clears valid bits before any use
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         if (sweep_we) begin
            valid_mem[0][wr_idx] <= 1'b0;
            valid_mem[1][wr_idx] <= 1'b0;
            lru_mem[wr_idx] <= 1'b0;
            if (st.sweep == ICRM_SW_CZERO) begin
               tag_mem[0][wr_idx] <= '0;
               tag_mem[1][wr_idx] <= '0;
            end
         end else if (fill_we) begin
            valid_mem[fill_way][wr_idx] <= 1'b1;
            tag_mem[fill_way][wr_idx] <= fill_tag;
            lru_mem[wr_idx] <= !fill_way;
         end
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign fetch_hit = st.fetch_hit;
   assign fetch_fill = st.fetch_fill;
   assign dram_zero_we = st.dram_zero_we;
   assign dram_addr = st.dram_addr;
   assign dram_busy = st.dz_busy;
   assign cram_zero_we = st.cram_zero_we;
   assign cram_addr = st.cram_addr;
   assign dram_clk_en = st.dram_clk_en;
   assign dram_pwr_en = st.dram_pwr_en;
   assign cram_clk_en = st.cram_clk_en;
   assign cram_pwr_en = st.cram_pwr_en;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_id_read;
      clk_en && setup && !pwrite && paddr == `ICRM_OFF_ID |=> pready
         && prdata == {16'h0000, `ICRM_CCHID, `ICRM_PARTNUM, `ICRM_RELNUM};
   endproperty
   a_id_read: assert property (p_id_read) else $error("id word wrong");

   property p_size_read;
      clk_en && setup && !pwrite && paddr == `ICRM_OFF_SIZE |=> pready
         && prdata == {`ICRM_MEMSZ_128K, `ICRM_CACHE_KB};
   endproperty
   a_size_read: assert property (p_size_read) else $error("size word wrong");

   property p_inval_clears_ready;
      clk_en && setup && pwrite && paddr == `ICRM_OFF_INVAL |=> !st.ready;
   endproperty
   a_inval_clears_ready: assert property (p_inval_clears_ready) else $error("ready kept");

   property p_disable_invalidates;
      clk_en && setup && pwrite && paddr == `ICRM_OFF_CTRL && st.enable && !pwdata[0]
         |=> !st.ready && !st.enable;
   endproperty
   a_disable_invalidates: assert property (p_disable_invalidates) else $error("no inval");

   property p_ready_after_sweep;
      $rose(st.ready) |-> $past(st.set_idx) == `ICRM_LAST_SET && st.sweep == ICRM_SW_IDLE;
   endproperty
   a_ready_after_sweep: assert property (p_ready_after_sweep) else $error("early ready");

   property p_hit_needs_ready;
      fetch_hit |-> $past(st.enable) && $past(st.ready) && $past(cram_ok);
   endproperty
   a_hit_needs_ready: assert property (p_hit_needs_ready) else $error("bad hit");

   property p_bypass;
      clk_en && fetch_req && (!st.enable || !st.ready) |=> fetch_fill && !fetch_hit;
   endproperty
   a_bypass: assert property (p_bypass) else $error("no bypass");

   property p_sleep_gates;
      clk_en && cram_light_sleep |=> !cram_clk_en && !cram_zero_we;
   endproperty
   a_sleep_gates: assert property (p_sleep_gates) else $error("cache clock on");

   property p_shutdown_gates;
      clk_en && dram_shutdown |=> !dram_pwr_en && !dram_clk_en && !dram_zero_we;
   endproperty
   a_shutdown_gates: assert property (p_shutdown_gates) else $error("power on");

   property p_wake_clears;
      clk_en && st.dsd_q && !dram_shutdown && !dram_light_sleep |=> dram_busy
         and (clk_en && dram_ok && !dram_zero_req |=> dram_zero_we && dram_addr == 12'h000);
   endproperty
   a_wake_clears: assert property (p_wake_clears) else $error("no clear on wake");

   property p_reserved_zero;
      clk_en && setup && !pwrite && paddr == `ICRM_OFF_CTRL
         |=> prdata[31:17] == 15'h0000 && prdata[15:1] == 15'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

   c_hit: cover property (fetch_hit);
   c_ready_rise: cover property ($rose(st.ready));
   c_dram_done: cover property ($fell(dram_busy));
   c_cram_zero: cover property (cram_zero_we && cram_addr == `ICRM_LAST_SET);
endmodule

/* icrm_pkg.sv */
// Types for the instruction cache and RAM manager.
// Relies on icrm_regs.svh for field widths.
`include "icrm_regs.svh"
package icrm_pkg;
   typedef enum logic [1:0] {
      ICRM_SW_IDLE  = 2'b00,
      ICRM_SW_INVAL = 2'b01,
      ICRM_SW_CZERO = 2'b10
   } icrm_sweep_t;

   typedef struct packed {
      logic                     enable;
      logic                     ready;
      icrm_sweep_t              sweep;
      logic [`ICRM_IDX_W-1:0]   set_idx;
      logic                     dz_busy;
      logic [`ICRM_DRAM_AW-1:0] dz_addr;
      logic                     dsd_q;
      logic                     csd_q;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic                     fetch_hit;
      logic                     fetch_fill;
      logic                     dram_zero_we;
      logic [`ICRM_DRAM_AW-1:0] dram_addr;
      logic                     cram_zero_we;
      logic [`ICRM_IDX_W-1:0]   cram_addr;
      logic                     dram_clk_en;
      logic                     dram_pwr_en;
      logic                     cram_clk_en;
      logic                     cram_pwr_en;
   } icrm_state_t;
endpackage

/* icrm_regs.svh */
// Register offsets, field positions, reset values and sweep counts for the cache/RAM manager.
// Included by the package; definitions only.
`ifndef ICRM_REGS_SVH
`define ICRM_REGS_SVH
`define ICRM_OFF_ID        12'h000
`define ICRM_OFF_SIZE      12'h004
`define ICRM_OFF_CTRL      12'h100
`define ICRM_OFF_INVAL     12'h700
`define ICRM_CTRL_EN       0
`define ICRM_CTRL_READY    16
`define ICRM_EN_RST        1'h0
`define ICRM_CACHE_KB      16'h0010
`define ICRM_MEMSZ_128K    16'h0004
`define ICRM_CCHID         6'h2a
`define ICRM_PARTNUM       4'h5
`define ICRM_RELNUM        6'h03
`define ICRM_SETS          512
`define ICRM_IDX_W         9
`define ICRM_TAG_W         19
`define ICRM_OFS_W         4
`define ICRM_LAST_SET      9'h1ff
`define ICRM_DRAM_AW       12
`define ICRM_DRAM_LAST     12'hfff
`endif

/* tb_icrm_instr_cache_ram_mgmt.sv */
// Self-checking bench for the cache control and RAM manager.
// Assumes registered one-cycle answers on the register and fetch ports.
`timescale 1ns/1ns
`include "icrm_regs.svh"
module tb_icrm_instr_cache_ram_mgmt;
   import icrm_pkg::*;
   logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, dram_addr;
   logic [31:0] pwdata, prdata, fetch_addr, r;
   logic        fetch_req, fetch_hit, fetch_fill, dram_busy;
   logic        dram_zero_req, cram_zero_req, dram_light_sleep, cram_light_sleep;
   logic        dram_shutdown, cram_shutdown, dram_zero_we, cram_zero_we;
   logic [8:0]  cram_addr;
   logic        dram_clk_en, dram_pwr_en, cram_clk_en, cram_pwr_en, clk_en;
   int          mismatches = 0;
   int          tests_run = 0;
   localparam logic [31:0] A = 32'h0000_1230;
   localparam logic [31:0] B = 32'h0000_3230;

   icrm_instr_cache_ram_mgmt dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_hit(fetch_hit), .fetch_fill(fetch_fill),
      .dram_zero_req(dram_zero_req), .cram_zero_req(cram_zero_req),
      .dram_light_sleep(dram_light_sleep), .cram_light_sleep(cram_light_sleep),
      .dram_shutdown(dram_shutdown), .cram_shutdown(cram_shutdown),
      .dram_zero_we(dram_zero_we), .dram_addr(dram_addr), .dram_busy(dram_busy),
      .cram_zero_we(cram_zero_we), .cram_addr(cram_addr), .dram_clk_en(dram_clk_en),
      .dram_pwr_en(dram_pwr_en), .cram_clk_en(cram_clk_en), .cram_pwr_en(cram_pwr_en));
   icrm_fetch_model m (.sys_clk(sys_clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .fetch_hit(fetch_hit), .fetch_fill(fetch_fill));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge sys_clk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      for (n = 0; n < 8; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      chk({31'h0, pready}, 32'h1);
      q   = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic err;
      apb(1'h0, a, 32'h0, r, err);
      chk(r, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic err;
      apb(1'h1, a, d, r, err);
   endtask
   task automatic poll_ready();
      int n;
      logic err;
      for (n = 0; n < 400; n++) begin
         apb(1'h0, `ICRM_OFF_CTRL, 32'h0, r, err);
         if (r[16] === 1'b1) break;
      end
      chk({31'h0, r[16]}, 32'h1);
   endtask
   task automatic fch(input logic [31:0] a, input logic [31:0] e);
      m.fetch(a, r);
      chk(r, e);
   endtask
   task automatic sweep(input bit dram, input int lim, input int e);
      int n = 0;
      repeat (lim) begin
         @(posedge sys_clk);
         if (dram && dram_zero_we === 1'b1) begin
            chk({20'h0, dram_addr}, n);
            n++;
         end
         if (!dram && cram_zero_we === 1'b1) begin
            chk({23'h0, cram_addr}, n);
            n++;
         end
      end
      chk(n, e);
      if (dram) chk({31'h0, dram_busy}, 32'h0);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
   endtask

   task automatic t_regs();
      logic err;
      rd(`ICRM_OFF_CTRL, 32'h0);
      rd(`ICRM_OFF_ID, {16'h0, `ICRM_CCHID, `ICRM_PARTNUM, `ICRM_RELNUM});
      rd(`ICRM_OFF_SIZE, {`ICRM_MEMSZ_128K, 16'h0010});
      rd(`ICRM_OFF_INVAL, 32'h0);
      apb(1'h0, 12'h008, 32'h0, r, err);
      chk({31'h0, err}, 32'h1);
      poll_ready();
      $display("test regs done");
   endtask
   task automatic t_fetch();
      fch(A, 32'h1);
      wr(`ICRM_OFF_CTRL, 32'hffff_ffff);
      rd(`ICRM_OFF_CTRL, 32'h0001_0001);
      fch(A, 32'h1);
      fch(A, 32'h2);
      fch(B, 32'h1);
      fch(A, 32'h2);
      fch(B, 32'h2);
      $display("test fetch done");
   endtask
   task automatic t_inval();
      wr(`ICRM_OFF_INVAL, 32'h0);
      rd(`ICRM_OFF_CTRL, 32'h1);
      fch(A, 32'h1);
      poll_ready();
      fch(A, 32'h1);
      wr(`ICRM_OFF_CTRL, 32'h0);
      rd(`ICRM_OFF_CTRL, 32'h0);
      poll_ready();
      fch(A, 32'h1);
      wr(`ICRM_OFF_CTRL, 32'h1);
      fch(A, 32'h1);
      fch(A, 32'h2);
      $display("test inval done");
   endtask
   task automatic t_zero();
      // A request seen while the clock enable is low must be ignored
      @(posedge sys_clk) clk_en <= 1'h0;
      dram_zero_req <= 1'h1;
      @(posedge sys_clk) dram_zero_req <= 1'h0;
      @(posedge sys_clk) clk_en <= 1'h1;
      settle(2);
      chk({31'h0, dram_busy}, 32'h0);
      @(posedge sys_clk) dram_zero_req <= 1'h1;
      @(posedge sys_clk) dram_zero_req <= 1'h0;
      sweep(1, 4300, 4096);
      @(posedge sys_clk) cram_zero_req <= 1'h1;
      @(posedge sys_clk) cram_zero_req <= 1'h0;
      sweep(0, 600, 512);
      poll_ready();
      fch(A, 32'h1);
      $display("test zero done");
   endtask
   task automatic t_sleep();
      @(posedge sys_clk) dram_light_sleep <= 1'h1;
      settle(3);
      chk({dram_clk_en, dram_pwr_en, cram_clk_en}, 32'h3);
      dram_light_sleep <= 1'h0;
      cram_light_sleep <= 1'h1;
      settle(3);
      chk({dram_clk_en, cram_clk_en, cram_pwr_en}, 32'h5);
      fch(A, 32'h1);
      @(posedge sys_clk) cram_light_sleep <= 1'h0;
      settle(3);
      fch(A, 32'h2);
      $display("test sleep done");
   endtask
   task automatic t_shut();
      @(posedge sys_clk) dram_shutdown <= 1'h1;
      settle(3);
      chk({dram_clk_en, dram_pwr_en}, 32'h0);
      @(posedge sys_clk) dram_shutdown <= 1'h0;
      sweep(1, 4300, 4096);
      @(posedge sys_clk) cram_shutdown <= 1'h1;
      settle(3);
      chk({cram_clk_en, cram_pwr_en}, 32'h0);
      @(posedge sys_clk) cram_shutdown <= 1'h0;
      sweep(0, 600, 512);
      poll_ready();
      fch(A, 32'h1);
      $display("test shut done");
   endtask

   task automatic complete_run();
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #400000;
      mismatches++;
      complete_run();
   end
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {dram_zero_req, cram_zero_req, dram_light_sleep, cram_light_sleep} = '0;
      {dram_shutdown, cram_shutdown} = '0;
      clk_en = 1'h1;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'h1;
      t_regs();
      t_fetch();
      t_inval();
      t_zero();
      t_sleep();
      t_shut();
      complete_run();
   end
endmodule
